// ---- design/ddrc_pkg.sv ----
/*
  Shared constants and types for the datapath command controller: register map,
  field layout, reset values, burst and latency figures, and the carrier types
  that bundle the datapath control strobes and the software configuration.
  Assumes a single system clock and a 32-bit APB register port.
*/
`default_nettype none

package ddrc_pkg;

  // one strobe group carries a 16-bit local word over 8 memory data lines
  localparam int GROUPS       = 2;
  localparam int GROUP_W      = 16;
  localparam int DATA_W       = GROUPS * GROUP_W;
  localparam int BE_W         = DATA_W / 8;

  // memory burst in system clock cycles (two beats per cycle)
  localparam int MEM_BURST    = 4;
  // fixed part of the read-return delay beyond the read-activity delay
  localparam int RD_RETURN_FIX = 4;
  // ddr2 write latency is cas latency less this many cycles
  localparam int DDR2_WR_LESS = 2;

  localparam int DLY_DEPTH    = 24;
  localparam int SEL_W        = 5;
  localparam int CNT_W        = 6;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] WDATA_OFF  = 8'h04;
  localparam logic [7:0] CMD_OFF    = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] RDATA_OFF  = 8'h10;

  // command and status bit positions
  localparam int CMD_WR_BIT   = 0;
  localparam int CMD_RD_BIT   = 1;
  localparam int CMD_BE_LSB   = 4;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_RDONE_BIT = 1;
  localparam int ST_REFU_BIT  = 2;

  // configuration word, low bits of the control register
  typedef struct packed {
    logic       reclock;
    logic [2:0] resync;
    logic [2:0] extra;
    logic [2:0] lb;
    logic [2:0] cl;
    logic       ddr2;
  } ddrc_cfg_t;

  localparam int CFG_W = $bits(ddrc_cfg_t);
  localparam ddrc_cfg_t CFG_RST = '{reclock: 1'b0, resync: 3'h0, extra: 3'h0,
                                    lb: 3'h4, cl: 3'h2, ddr2: 1'b0};

  // strobes towards the datapath
  typedef struct packed {
    logic doing_rd;
    logic dqs_burst;
    logic wdata_valid;
    logic doing_wr;
  } ddrc_dp_ctl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WR,
    ST_RD
  } ddrc_state_t;

endpackage

`default_nettype wire

// ---- design/ddrc_tap_delay.sv ----
/*
  Shift-register delay with a run-time tap: dout is din delayed by sel+1 cycles.
  Assumes sel is held steady while data is in flight.
*/
`timescale 1ns/1ps
`default_nettype none

module ddrc_tap_delay
  import ddrc_pkg::*;
#(
  parameter int DEPTH = DLY_DEPTH,
  parameter int SW    = SEL_W
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          din,
  input  wire logic [SW-1:0] sel,
  output logic               dout
);

  logic [DEPTH-1:0] stage;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage[0] <= 1'b0;
    end else begin
      stage[0] <= din;
    end
  end

  for (genvar i = 1; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        stage[i] <= 1'b0;
      end else begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[sel];

endmodule

`default_nettype wire

// ---- design/ddrc_host_ctl.sv ----
/*
  Command controller that drives a strobe-group DDR/DDR2 datapath: write and
  read activity flags, write-data strobe, strobe-burst enable, write word and
  byte-lane enables, and read-return valid with read word capture.
  Software orders single bursts through APB registers.
  Assumes the datapath runs on the same clock and its read word is synchronous.

// Notes on behaviour
// - write-data strobe is a registered copy of the write-data request
// - strobe-burst enable stays up longer than the write-activity flag
// - write word is valid in the cycle of the write-data strobe
// - byte-lane enables valid with the strobe; datapath turns them into mask
// - read-activity starts at the read command and lasts the full burst
// - read-activity is further delayed for command pipes and registered dimms
// - write-data strobe is asserted again once the write is in progress
// - read-return valid follows read-activity by a further 4 plus R cycles
// - ddr: write-activity starts with the write command, lasts the burst
// - ddr2: write-activity starts cas latency minus 2 after the command
// - ddr2: write-activity and write-data strobe are identical
// - full bursts: strobe-burst enable lasts one cycle beyond write-activity
// - short bursts: strobe-burst enable still covers the full memory burst
*/
`timescale 1ns/1ps
`default_nettype none

module ddrc_host_ctl
  import ddrc_pkg::*;
#(
  parameter int MB = MEM_BURST
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output ddrc_dp_ctl_t           dp_ctl,
  output logic      [DATA_W-1:0] wdata,
  output logic      [BE_W-1:0]   byte_lane_enables,
  output logic                   read_return_valid,
  input  wire logic [DATA_W-1:0] rdata
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  localparam logic [CNT_W-1:0] MB_C = CNT_W'(MB);

  ddrc_state_t           state;
  logic [CNT_W-1:0]      cnt;
  ddrc_cfg_t             cfg;
  logic [DATA_W-1:0]     wdata_reg;
  logic [BE_W-1:0]       be_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic                  rd_done;
  logic                  refused;

  // ---------------- apb decode ----------------
  wire acc_first = psel && penable && !pready;
  wire acc_done  = psel && penable && pready;
  wire wr_done   = acc_done && pwrite;
  wire idle      = (state == ST_IDLE);

  wire hit_ctrl  = hit(paddr, CTRL_OFF);
  wire hit_wdata = hit(paddr, WDATA_OFF);
  wire hit_cmd   = hit(paddr, CMD_OFF);
  wire hit_stat  = hit(paddr, STATUS_OFF);
  wire hit_rdata = hit(paddr, RDATA_OFF);
  wire mapped    = hit_ctrl || hit_wdata || hit_cmd || hit_stat || hit_rdata;

  wire [31:0] status_word = {29'h0, refused, rd_done, !idle};
  wire [31:0] cmd_word    = 32'(be_reg) << CMD_BE_LSB;

  wire [31:0] next_prdata =
    hit_ctrl  ? 32'(cfg)       :
    hit_wdata ? 32'(wdata_reg) :
    hit_cmd   ? cmd_word       :
    hit_stat  ? status_word    :
    hit_rdata ? 32'(rdata_reg) : 32'h0000_0000;

  // a write to control or command while a burst runs is dropped and flagged
  wire cfg_wr    = wr_done && hit_ctrl;
  wire cmd_wr    = wr_done && hit_cmd;
  wire stat_wr   = wr_done && hit_stat;
  wire start_wr  = cmd_wr && idle && pwdata[CMD_WR_BIT];
  wire start_rd  = cmd_wr && idle && pwdata[CMD_RD_BIT] && !pwdata[CMD_WR_BIT];
  wire set_refu  = (cfg_wr || cmd_wr) && !idle;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first && !mapped;
      prdata  <= (acc_first && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg       <= CFG_RST;
      wdata_reg <= '0;
      be_reg    <= '0;
    end else begin
      if (cfg_wr && idle) begin
        cfg <= ddrc_cfg_t'(pwdata[CFG_W-1:0]);
      end
      if (wr_done && hit_wdata) begin
        wdata_reg <= pwdata[DATA_W-1:0];
      end
      if (cmd_wr && idle) begin
        be_reg <= pwdata[CMD_BE_LSB +: BE_W];
      end
    end
  end

  // ---------------- timing figures from the configuration ----------------
  wire [CNT_W-1:0] lb_raw  = CNT_W'(cfg.lb);
  wire [CNT_W-1:0] lb_eff  = (lb_raw == '0) ? CNT_W'(1) : ((lb_raw > MB_C) ? MB_C : lb_raw);
  wire [CNT_W-1:0] cl_c    = CNT_W'(cfg.cl);
  wire             cl_ok   = cl_c >= CNT_W'(DDR2_WR_LESS);
  wire [CNT_W-1:0] wr_lat  = (cfg.ddr2 && cl_ok) ? cl_c - CNT_W'(DDR2_WR_LESS) : '0;
  wire [SEL_W-1:0] rd_tap  = SEL_W'(cfg.extra);
  wire [SEL_W-1:0] rv_tap  = SEL_W'(cfg.extra) + SEL_W'(RD_RETURN_FIX) + SEL_W'(cfg.resync)
                             + SEL_W'(cfg.reclock);
  wire [CNT_W-1:0] wr_end  = wr_lat + MB_C + CNT_W'(1);
  wire [CNT_W-1:0] rd_end  = CNT_W'(rv_tap) + MB_C + CNT_W'(2);

  // ---------------- burst sequencer ----------------
  wire in_wr      = (state == ST_WR);
  wire in_rd      = (state == ST_RD);
  wire wr_window  = in_wr && (cnt >= wr_lat) && (cnt < wr_lat + lb_eff);
  // one request per written word, so it doubles as the write-activity window
  wire wr_req     = wr_window;
  // strobe covers the whole memory burst plus one cycle, whatever the local length
  wire dqs_window = in_wr && (cnt >= wr_lat) && (cnt <= wr_lat + MB_C);
  wire rd_src     = in_rd && (cnt < MB_C);
  wire rd_dly;
  wire rv_dly;

  ddrc_tap_delay #(
    .DEPTH (DLY_DEPTH),
    .SW    (SEL_W)
  ) u_rd_dly (
    .clock (clock),
    .rst_n (rst_n),
    .din   (rd_src),
    .sel   (rd_tap),
    .dout  (rd_dly)
  );

  ddrc_tap_delay #(
    .DEPTH (DLY_DEPTH),
    .SW    (SEL_W)
  ) u_rv_dly (
    .clock (clock),
    .rst_n (rst_n),
    .din   (rd_src),
    .sel   (rv_tap),
    .dout  (rv_dly)
  );

  wire seq_last = (in_wr && cnt == wr_end) || (in_rd && cnt == rd_end);

  ddrc_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_wr) begin
          next_state = ST_WR;
        end else if (start_rd) begin
          next_state = ST_RD;
        end
      end
      ST_WR,
      ST_RD: begin
        if (seq_last) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  wire [CNT_W-1:0] next_cnt = (idle || seq_last) ? '0 : cnt + CNT_W'(1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ---------------- datapath strobes, all registered ----------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dp_ctl            <= '0;
      read_return_valid <= 1'b0;
    end else begin
      dp_ctl.doing_wr    <= wr_window;
      dp_ctl.wdata_valid <= wr_req;
      dp_ctl.dqs_burst   <= dqs_window;
      dp_ctl.doing_rd    <= rd_dly;
      read_return_valid  <= rv_dly;
    end
  end

  // word and lane enables are frozen for the whole burst
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wdata             <= '0;
      byte_lane_enables <= '0;
    end else if (start_wr) begin
      wdata             <= wdata_reg;
      byte_lane_enables <= pwdata[CMD_BE_LSB +: BE_W];
    end
  end

  // ---------------- read capture and status ----------------
  wire set_rdone = in_rd && seq_last;
  wire clr_rdone = stat_wr && pwdata[ST_RDONE_BIT];
  wire clr_refu  = stat_wr && pwdata[ST_REFU_BIT];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      rd_done   <= 1'b0;
      refused   <= 1'b0;
    end else begin
      if (read_return_valid) begin
        rdata_reg <= rdata;
      end
      rd_done <= set_rdone || (rd_done && !clr_rdone);
      refused <= set_refu || (refused && !clr_refu);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [CNT_W-1:0] dqs_run;
  logic [CNT_W-1:0] wr_run;
  logic [CNT_W-1:0] rd_run;
  logic [CNT_W-1:0] rv_run;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dqs_run <= '0;
      wr_run  <= '0;
      rd_run  <= '0;
      rv_run  <= '0;
    end else begin
      dqs_run <= dp_ctl.dqs_burst ? dqs_run + CNT_W'(1) : '0;
      wr_run  <= dp_ctl.doing_wr ? wr_run + CNT_W'(1) : '0;
      rd_run  <= dp_ctl.doing_rd ? rd_run + CNT_W'(1) : '0;
      rv_run  <= read_return_valid ? rv_run + CNT_W'(1) : '0;
    end
  end

  ddr2_ident_a: assert property (cfg.ddr2 |-> dp_ctl.wdata_valid == dp_ctl.doing_wr)
    else $error("ddr2 write strobe differs from write activity");
  wdata_hold_a: assert property (dp_ctl.wdata_valid |-> $stable(wdata) && $stable(byte_lane_enables))
    else $error("write word or lane enables move during the write strobe");
  lane_match_a: assert property (dp_ctl.wdata_valid |-> byte_lane_enables == be_reg)
    else $error("lane enables differ from the ordered enables");
  dqs_tail_a: assert property ($fell(dp_ctl.doing_wr) |-> dp_ctl.dqs_burst ##1 !dp_ctl.dqs_burst[*1]
                               or dp_ctl.dqs_burst)
    else $error("strobe burst ends with write activity");
  dqs_len_a: assert property ($fell(dp_ctl.dqs_burst) |-> dqs_run == MB_C + CNT_W'(1))
    else $error("strobe burst length is not the memory burst plus one");
  full_tail_a: assert property ($fell(dp_ctl.doing_wr) && wr_run == MB_C |-> dp_ctl.dqs_burst ##1 !dp_ctl.dqs_burst)
    else $error("full burst strobe not exactly one cycle longer");
  wr_len_a: assert property ($fell(dp_ctl.doing_wr) |-> wr_run == lb_eff)
    else $error("write activity length differs from local burst");
  wr_lat_a: assert property ($rose(dp_ctl.doing_wr) |-> cnt == wr_lat + CNT_W'(1))
    else $error("write activity starts at the wrong latency");
  wr_req_a: assert property ($rose(dp_ctl.doing_wr) |-> dp_ctl.wdata_valid)
    else $error("no write strobe once the write is in progress");
  rd_len_a: assert property ($fell(dp_ctl.doing_rd) |-> rd_run == MB_C)
    else $error("read activity is not one full burst");
  rd_lat_a: assert property ($rose(dp_ctl.doing_rd) |-> cnt == CNT_W'(rd_tap) + CNT_W'(2))
    else $error("read activity delay wrong");
  rv_lat_a: assert property ($rose(read_return_valid) |-> cnt == CNT_W'(rv_tap) + CNT_W'(2))
    else $error("read return valid delay wrong");
  apb_ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");

  // request, word and strobe-burst timing towards the datapath
  wreq_reg_a: assert property (dp_ctl.wdata_valid == $past(wr_req))
    else $error("write strobe is not the registered write request");
  wword_load_a: assert property ($rose(in_wr) |-> wdata == $past(wdata_reg))
    else $error("write word not taken from the staged word");
  wr_busy_a: assert property (dp_ctl.wdata_valid |-> in_wr)
    else $error("write strobe outside a write burst");
  dqs_cover_a: assert property (dp_ctl.doing_wr |-> dp_ctl.dqs_burst)
    else $error("write activity without strobe burst");
  dqs_start_a: assert property ($rose(dp_ctl.dqs_burst) |-> $rose(dp_ctl.doing_wr))
    else $error("strobe burst does not start with write activity");

  // read return and bus turnaround
  rd_excl_a: assert property (!(dp_ctl.doing_rd && (dp_ctl.doing_wr || dp_ctl.dqs_burst)))
    else $error("read activity overlaps a write");
  rv_len_a: assert property ($fell(read_return_valid) |-> rv_run == MB_C)
    else $error("read return valid is not one full burst");
  rv_after_rd_a: assert property ($rose(read_return_valid) |-> !dp_ctl.doing_rd)
    else $error("read return valid starts before read activity ends");

  // apb answer and status flags
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("apb ready held for more than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("apb error without ready");
  refu_set_a: assert property (set_refu |=> refused)
    else $error("dropped command not flagged");
  rdone_set_a: assert property (set_rdone |=> rd_done)
    else $error("read done not set at burst end");

endmodule

`default_nettype wire

// ---- bench/ddrc_dp_model.sv ----
/*
  Behavioural model of the strobe-group datapath: pin enables, write staging,
  data mask, per-group cas pipeline gating capture, read word loopback.
  Assumes the controller's dp_ctl, wdata and byte_lane_enables on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ddrc_dp_model
  import ddrc_pkg::*;
#(
  parameter int CL = 2
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire ddrc_dp_ctl_t        dp_ctl,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [BE_W-1:0]     byte_lane_enables,
  output logic      [DATA_W-1:0]   rdata,
  output logic                     dq_oe_n,
  output logic                     dqs_oe_n,
  output logic      [BE_W-1:0]     dm
);
  ddrc_dp_ctl_t      ctl_q;
  logic [DATA_W-1:0] stage;
  logic [BE_W-1:0]   be_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_q    <= '0;
      dq_oe_n  <= 1'b1;
      dqs_oe_n <= 1'b1;
    end else begin
      ctl_q    <= dp_ctl;
      dq_oe_n  <= ~ctl_q.doing_wr;
      dqs_oe_n <= ~ctl_q.dqs_burst;
    end
    if (dp_ctl.wdata_valid) begin
      stage <= wdata;
      be_q  <= byte_lane_enables;
    end
  end

  assign dm = ~be_q;

  for (genvar g = 0; g < GROUPS; g++) begin : grp
    logic [CL:0] pipe;
    logic        post;
    // own cas pipeline per group, last stage feeds the postamble register
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pipe <= '0;
        post <= 1'b0;
        rdata[g*GROUP_W +: GROUP_W] <= '1;
      end else begin
        pipe <= {pipe[CL-1:0], ctl_q.doing_rd};
        post <= pipe[CL];
        if (post) begin
          rdata[g*GROUP_W +: GROUP_W] <= stage[g*GROUP_W +: GROUP_W];
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the datapath command controller over APB.
  Assumes the datapath model on the far side and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ddrc_pkg::*;
  localparam int MB = MEM_BURST;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, read_return_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, exp_w;
  logic [3:0] exp_be, dm;
  logic [DATA_W-1:0] wdata, rdata;
  logic [BE_W-1:0] byte_lane_enables;
  logic dq_oe_n, dqs_oe_n;
  ddrc_dp_ctl_t dp_ctl;
  int n_fail, comparisons, cyc, t_take, t_wr, t_rd, t_rv, n_wr, n_dqs, n_rd, n_rv, n_dqoe, n_dqsoe, n_wmis;

  ddrc_host_ctl dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_ctl(dp_ctl),
    .wdata(wdata), .byte_lane_enables(byte_lane_enables), .read_return_valid(read_return_valid), .rdata(rdata));
  ddrc_dp_model dp_u (.clock(clock), .rst_n(rst_n), .dp_ctl(dp_ctl), .wdata(wdata),
    .byte_lane_enables(byte_lane_enables), .rdata(rdata), .dq_oe_n(dq_oe_n), .dqs_oe_n(dqs_oe_n), .dm(dm));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // a stamp is the count at the first edge that samples the registered output high
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dp_ctl.doing_wr === 1'b1) begin n_wr++; if (t_wr < 0) t_wr = cyc; end
    if (dp_ctl.doing_rd === 1'b1) begin n_rd++; if (t_rd < 0) t_rd = cyc; end
    if (read_return_valid === 1'b1) begin n_rv++; if (t_rv < 0) t_rv = cyc; end
    if (dp_ctl.dqs_burst === 1'b1) n_dqs++;
    if (dq_oe_n === 1'b0) n_dqoe++;
    if (dqs_oe_n === 1'b0) n_dqsoe++;
    if (dp_ctl.wdata_valid !== dp_ctl.doing_wr) n_wmis++;
    if (dp_ctl.doing_wr === 1'b1 && (wdata !== exp_w || byte_lane_enables !== exp_be)) n_wmis++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic clr();
    {n_wr, n_dqs, n_rd, n_rv, n_dqoe, n_dqsoe, n_wmis} = '0;
    t_wr = -1;
    t_rd = -1;
    t_rv = -1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    t_take = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic do_write(input logic d2, input logic [2:0] cl, input logic [2:0] lb, input logic [31:0] d,
                          input logic [3:0] be);
    ddrc_cfg_t c;
    logic [31:0] q;
    logic e;
    int w;
    int n;
    c = CFG_RST;
    c.ddr2 = d2;
    c.cl = cl;
    c.lb = lb;
    w = (d2 && cl >= 2) ? int'(cl) - DDR2_WR_LESS : 0;
    // local burst of 0 runs one cycle, anything above the memory burst is clipped
    n = (lb == 3'h0) ? 1 : ((int'(lb) > MB) ? MB : int'(lb));
    apb(1'b1, CTRL_OFF, 32'(c), q, e);
    apb(1'b1, WDATA_OFF, d, q, e);
    exp_w = d;
    exp_be = be;
    clr();
    apb(1'b1, CMD_OFF, {24'h0, be, 4'h1}, q, e);
    repeat (20) @(posedge clock);
    check(32'(t_wr - t_take), 32'(w + 2));
    check(32'(n_wr), 32'(n));
    check(32'(n_dqs), 32'(MB + 1));
    check(32'(n_dqoe), 32'(n));
    check(32'(n_dqsoe), 32'(MB + 1));
    check(32'(n_wmis), 32'h0);
    check({28'h0, dm}, {28'h0, ~be});
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    check({28'h0, dp_ctl}, 32'h0);
    check({31'h0, dq_oe_n}, 32'h1);
    apb(1'b0, CTRL_OFF, 32'h0, q, e);
    check(q, 32'(CFG_RST));
    $display("reset test done");
  endtask

  task automatic t_writes();
    do_write(1'b0, 3'h2, 3'h4, 32'ha5c3_1e0f, 4'h5);
    do_write(1'b0, 3'h2, 3'h2, 32'h0f1e_2d3c, 4'ha);
    do_write(1'b1, 3'h4, 3'h4, 32'h6b7c_8d9e, 4'h3);
    do_write(1'b0, 3'h2, 3'h0, 32'h2468_ace0, 4'h9);
    do_write(1'b1, 3'h5, 3'h7, 32'h9abc_def0, 4'h6);
    do_write(1'b1, 3'h3, 3'h4, 32'h1357_9bdf, 4'he);
    $display("write tests done");
  endtask

  task automatic do_read(input logic [2:0] ex, input logic [2:0] rs, input logic rc);
    ddrc_cfg_t c;
    logic [31:0] q;
    logic e;
    c = CFG_RST;
    c.extra = ex;
    c.resync = rs;
    c.reclock = rc;
    apb(1'b1, CTRL_OFF, 32'(c), q, e);
    clr();
    apb(1'b1, CMD_OFF, 32'h2, q, e);
    repeat (40) @(posedge clock);
    check(32'(t_rd - t_take), 32'(ex) + 32'h3);
    check(32'(n_rd), 32'(MB));
    check(32'(t_rv - t_rd), 32'(RD_RETURN_FIX) + 32'(rs) + 32'(rc));
    check(32'(n_rv), 32'(MB));
    apb(1'b0, RDATA_OFF, 32'h0, q, e);
    check(q, exp_w);
  endtask

  task automatic t_read();
    logic [31:0] q;
    logic e;
    do_read(3'h0, 3'h2, 1'b1);
    do_read(3'h3, 3'h0, 1'b0);
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    check({31'h0, q[ST_RDONE_BIT]}, 32'h1);
    apb(1'b1, STATUS_OFF, 32'h2, q, e);
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    check(q, 32'h0);
    $display("read test done");
  endtask

  task automatic t_refuse();
    logic [31:0] q;
    logic e;
    apb(1'b1, CMD_OFF, 32'hf1, q, e);
    apb(1'b1, CMD_OFF, 32'h02, q, e);
    repeat (20) @(posedge clock);
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    check({31'h0, q[ST_REFU_BIT]}, 32'h1);
    check({31'h0, q[ST_RDONE_BIT]}, 32'h0);
    apb(1'b1, STATUS_OFF, 32'h4, q, e);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    apb(1'b1, RDATA_OFF, 32'hffff_ffff, q, e);
    check({31'h0, e}, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0, q, e);
    check(q, 32'h0);
    $display("refusal test done");
  endtask

  initial begin
    #40000;
    n_fail++;
    conclude();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, comparisons, cyc, t_take} = '0;
    clr();
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    t_reset();
    t_writes();
    t_read();
    t_refuse();
    conclude();
  end
endmodule

`default_nettype wire
